// ===== lsled_top.sv
// Purpose: Drives communication, alarm and fuse lamps of one unit
// Assumes: Status inputs come from unit pins, so they are synchronised
// Notes: Pattern phases are shared so lamps blink in step
module lsled_top #(
  parameter int unsigned TICK_CYC = lsled_pkg::TICK_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Link state
  input wire logic newer_mode_i,
  input wire logic comm_active_i,
  input wire logic comm_halt_i,
  input wire logic safety_mon_i,
  // Alarm sources and fuse indication
  input wire logic hw_alarm_i,
  input wire logic master_alarm_i,
  input wire logic down_break_i,
  input wire logic down_pwr_fail_i,
  input wire logic status_alarm_i,
  input wire logic fuse_blown_i,
  // Lamps
  output logic comm_lamp_o,
  output logic alarm_lamp_o,
  output logic fuse_lamp_o
);
  localparam int unsigned NIN = 10;
  logic [NIN-1:0] raw;
  logic [NIN-1:0] s1_q;
  logic [NIN-1:0] s2_q;
  logic [lsled_pkg::PHASE_W-1:0] phase;
  lsled_pkg::lsled_pat_t comm_pat;
  lsled_pkg::lsled_pat_t alarm_pat;
  logic newer, active, halt, safe, hw, mst, brk, pwr, sts, fuse;

  assign raw = {newer_mode_i, comm_active_i, comm_halt_i, safety_mon_i,
                hw_alarm_i, master_alarm_i, down_break_i, down_pwr_fail_i,
                status_alarm_i, fuse_blown_i};

  // Pins are asynchronous to the unit clock
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end

  assign {newer, active, halt, safe, hw, mst, brk, pwr, sts, fuse} = s2_q;

  // Two flops per pin; no logic may tap the first stage
  sync_depth_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    rstn_i
    |-> ##2 s2_q == $past(raw, 2))
    else $error("pin synchroniser depth wrong");

  lsled_tick #(.TICK_CYC(TICK_CYC)) u_tick (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .phase_o(phase)
  );

  // Halt outranks running traffic so the alarm cause is visible
  always_comb begin
    if (halt) begin
      comm_pat = lsled_pkg::LSLED_BFAST;
    end else if (active && !newer) begin
      comm_pat = lsled_pkg::LSLED_B13;
    end else if (active && safe) begin
      comm_pat = lsled_pkg::LSLED_B31;
    end else if (active) begin
      comm_pat = lsled_pkg::LSLED_B11;
    end else begin
      comm_pat = lsled_pkg::LSLED_ON;
    end
  end

  // Release edge excluded: the lamp flop is still in reset there
  idle_on_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    rstn_i && !halt && !active
    |=> comm_lamp_o)
    else $error("comm lamp dark before communication");

  halt_fast_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    halt
    |=> comm_lamp_o == !$past(phase[0]))
    else $error("halted comm lamp not fast blink");

  legacy_run_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    active && !halt && !newer
    |=> comm_lamp_o == ($past(phase[2:1]) == 2'h0))
    else $error("legacy comm lamp not 1:3 blink");

  newer_run_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    active && !halt && newer && !safe
    |=> comm_lamp_o == !$past(phase[1]))
    else $error("newer comm lamp not 1:1 blink");

  safety_run_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    active && !halt && newer && safe
    |=> comm_lamp_o == !($past(phase[2]) && $past(phase[1])))
    else $error("safety comm lamp not 3:1 blink");

  // Local hardware fault first; downstream faults only in newer mode
  always_comb begin
    if (hw) begin
      alarm_pat = lsled_pkg::LSLED_ON;
    end else if (mst) begin
      alarm_pat = lsled_pkg::LSLED_BFAST;
    end else if (newer && brk) begin
      alarm_pat = lsled_pkg::LSLED_B11;
    end else if (newer && pwr) begin
      alarm_pat = lsled_pkg::LSLED_B31;
    end else if (newer && sts) begin
      alarm_pat = lsled_pkg::LSLED_B13;
    end else begin
      alarm_pat = lsled_pkg::LSLED_OFF;
    end
  end

  hw_steady_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    hw
    |=> alarm_lamp_o)
    else $error("hardware alarm lamp not steady on");

  master_fast_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    !hw && mst
    |=> alarm_lamp_o == !$past(phase[0]))
    else $error("master alarm not fast blink");

  break_blink_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    !hw && !mst && newer && brk
    |=> alarm_lamp_o == !$past(phase[1]))
    else $error("broken link alarm not 1:1 blink");

  pwr_blink_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    !hw && !mst && newer && !brk && pwr
    |=> alarm_lamp_o == !($past(phase[2]) && $past(phase[1])))
    else $error("power loss alarm not 3:1 blink");

  status_blink_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    !hw && !mst && newer && !brk && !pwr && sts
    |=> alarm_lamp_o == ($past(phase[2:1]) == 2'h0))
    else $error("status alarm not 1:3 blink");

  // Legacy units cannot report downstream faults, so they stay dark
  legacy_quiet_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    !hw && !mst && !newer
    |=> !alarm_lamp_o)
    else $error("legacy alarm lamp lit by downstream fault");

  alarm_dark_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    !hw && !mst && !brk && !pwr && !sts
    |=> !alarm_lamp_o)
    else $error("alarm lamp lit without alarm");

  hw_first_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    hw && (mst || brk || pwr || sts)
    |=> alarm_lamp_o)
    else $error("hardware alarm outranked");

  master_outranks_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    !hw && mst && newer && (brk || pwr || sts)
    |=> alarm_lamp_o == !$past(phase[0]))
    else $error("master alarm outranked by downstream fault");

  // Three separate lamp flops
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      comm_lamp_o <= 1'b0;
    end else begin
      comm_lamp_o <= lsled_pkg::lsled_lit(comm_pat, phase);
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      alarm_lamp_o <= 1'b0;
    end else begin
      alarm_lamp_o <= lsled_pkg::lsled_lit(alarm_pat, phase);
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fuse_lamp_o <= 1'b0;
    end else begin
      fuse_lamp_o <= fuse;
    end
  end

  // Fuse needs no pattern, only the output flop
  fuse_follow_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    ##1 fuse_lamp_o == $past(fuse))
    else $error("fuse lamp does not follow fuse input");

  // Lamps may move only when the phase or a pin moved
  lamp_steady_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    rstn_i && $past(rstn_i) && $stable(phase) && $stable(s2_q)
    |=> $stable(comm_lamp_o) && $stable(alarm_lamp_o))
    else $error("lamp changed between ticks");
endmodule

// ===== lsled_pkg.sv
// Purpose: Constants and types for the unit status lamp driver
// Assumes: 125 MHz unit clock, asynchronous active-low reset
// Notes: Overview list below; lamp patterns built from a 0.25 s tick
//
// Overview of operation
// - Three lamps: communication, alarm, fuse
// - Normal blink: 0.5 s on, 0.5 s off
// - Long blink: 1.5 s on, 0.5 s off
// - Short blink: 0.5 s on, 1.5 s off
// - Fast blink: 0.25 s on, 0.25 s off
// - Comm lamp steady on before communication
// - Comm halted by alarm: fast blink
// - Communicating: legacy 1:3, newer 1:1 or 3:1
// - Alarm lamp reflects local or downstream alarms
// - Hardware alarm: alarm lamp steady on
// - Newer mode: signal broken downstream connection
// - Broken downstream connection uses 1:1 blink
// - Downstream power loss: 3:1 blink (newer mode only)
// - Status alarm: 1:3 blink (newer mode only)
// - Master commanded alarm: fast blink
// - Fuse lamp follows fuse-blown indication
package lsled_pkg;
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned TICK_MS = 250;
  localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned PHASE_W = 3;
  // Phase counts 0..7, each 0.25 s; full period 2 s
  localparam logic [PHASE_W-1:0] PH_LAST = 3'h7;

  typedef enum logic [2:0] {
    LSLED_OFF  = 3'h0,
    LSLED_ON   = 3'h1,
    LSLED_B11  = 3'h3,
    LSLED_B31  = 3'h2,
    LSLED_B13  = 3'h6,
    LSLED_BFAST = 3'h7
  } lsled_pat_t;

  // Lamp level for a pattern at a given phase
  function automatic logic lsled_lit(lsled_pat_t p, logic [PHASE_W-1:0] ph);
    logic r;
    r = 1'b0;
    unique case (p)
      LSLED_OFF: r = 1'b0;
      LSLED_ON: r = 1'b1;
      LSLED_B11: r = ~ph[1];
      LSLED_B31: r = ~(ph[2] & ph[1]);
      LSLED_B13: r = ~(ph[2] | ph[1]);
      LSLED_BFAST: r = ~ph[0];
      default: r = 1'b0;
    endcase
    return r;
  endfunction
endpackage

// ===== lsled_tick.sv
// Purpose: Free-running 0.25 s tick and pattern phase counter
// Assumes: Single unit clock
// Notes: Phase restarts at zero after reset
module lsled_tick #(
  parameter int unsigned TICK_CYC = lsled_pkg::TICK_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Phase out
  output logic [lsled_pkg::PHASE_W-1:0] phase_o
);
  logic [26:0] cnt_q;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q <= 27'h0;
    end else if (cnt_q == 27'(TICK_CYC - 1)) begin
      cnt_q <= 27'h0;
    end else begin
      cnt_q <= cnt_q + 27'h1;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      phase_o <= '0;
    end else if (cnt_q == 27'(TICK_CYC - 1)) begin
      phase_o <= phase_o + 3'h1;
    end
  end

  tick_wrap_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    cnt_q == 27'(TICK_CYC - 1)
    |=> cnt_q == 27'h0)
    else $error("tick counter did not wrap");

  phase_step_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    cnt_q == 27'(TICK_CYC - 1)
    |=> phase_o == $past(phase_o) + 3'h1)
    else $error("phase did not advance on tick");

  phase_hold_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    cnt_q != 27'(TICK_CYC - 1)
    |=> $stable(phase_o))
    else $error("phase moved between ticks");
endmodule

// ===== lsled_viewer.sv
// Purpose: Watches one lamp and measures its lit and dark run lengths
// Assumes: Lamp is a level sampled on the unit clock
// Notes: Lengths are in clock cycles, not seconds
module lsled_viewer (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Lamp under watch
  input wire logic lamp_i,
  // Run lengths
  output logic [15:0] cur_o,
  output logic [15:0] on_o,
  output logic [15:0] off_o
);
  logic prev_q;
  // Saturate so a steady lamp never wraps back to a short run
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prev_q <= 1'b0;
      cur_o <= 16'h0;
      on_o <= 16'h0;
      off_o <= 16'h0;
    end else begin
      prev_q <= lamp_i;
      if (lamp_i == prev_q) begin
        cur_o <= (cur_o == 16'hffff) ? cur_o : cur_o + 16'h1;
      end else begin
        cur_o <= 16'h1;
        if (prev_q) begin
          on_o <= cur_o;
        end else begin
          off_o <= cur_o;
        end
      end
    end
  end
endmodule

// ===== tb.sv
// Purpose: Self-checking bench for the unit status lamp driver
// Assumes: Short tick of 4 cycles, so 0.25 s maps to 4 cycles
// Notes: Rows hold input bits and lit/dark ticks for the comm and alarm lamps
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 4;
  typedef struct {logic [9:0] in; int co, cf, ao, af;} lsled_row_t;
  logic clk, rstn, comm_l, alarm_l, fuse_l;
  logic [9:0] ins;
  logic [15:0] cc, con, cof, ac, aon, aof;
  int n_errors = 0;
  int n_compared = 0;
  // Ticks lit, ticks dark; (1,0) steady on, (0,1) steady off
  lsled_row_t rows[17] = '{
    '{10'b0000000000, 1, 0, 0, 1}, '{10'b0100000000, 2, 6, 0, 1},
    '{10'b1100000000, 2, 2, 0, 1}, '{10'b1101000000, 6, 2, 0, 1},
    '{10'b0110000000, 1, 1, 0, 1}, '{10'b1000100000, 1, 0, 1, 0},
    '{10'b1000001000, 1, 0, 2, 2}, '{10'b1000000101, 1, 0, 6, 2},
    '{10'b1000000010, 1, 0, 2, 6}, '{10'b0000010000, 1, 0, 1, 1},
    '{10'b0000001110, 1, 0, 0, 1}, '{10'b1000111000, 1, 0, 1, 0},
    '{10'b1000011100, 1, 0, 1, 1}, '{10'b1001000000, 1, 0, 0, 1},
    '{10'b1110000000, 1, 1, 0, 1}, '{10'b1000001100, 1, 0, 2, 2},
    '{10'b1000000110, 1, 0, 6, 2}};
  lsled_top #(.TICK_CYC(TK)) dut (.clk_i(clk), .rstn_i(rstn),
    .newer_mode_i(ins[9]), .comm_active_i(ins[8]), .comm_halt_i(ins[7]),
    .safety_mon_i(ins[6]), .hw_alarm_i(ins[5]), .master_alarm_i(ins[4]),
    .down_break_i(ins[3]), .down_pwr_fail_i(ins[2]),
    .status_alarm_i(ins[1]), .fuse_blown_i(ins[0]),
    .comm_lamp_o(comm_l), .alarm_lamp_o(alarm_l), .fuse_lamp_o(fuse_l));
  lsled_viewer v_comm (.clk_i(clk), .rstn_i(rstn), .lamp_i(comm_l),
    .cur_o(cc), .on_o(con), .off_o(cof));
  lsled_viewer v_alarm (.clk_i(clk), .rstn_i(rstn), .lamp_i(alarm_l),
    .cur_o(ac), .on_o(aon), .off_o(aof));
  always #4 clk = ~clk;
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Steady lamps must hold a long run; blinking ones match both runs
  task automatic chk(input logic l, input logic [15:0] c, o, f,
                     input int eo, ef);
    if (eo == 0 || ef == 0) begin
      cmp({15'h0, l}, (ef == 0) ? 16'h1 : 16'h0);
      cmp({15'h0, c >= 16'd88}, 16'h1);
    end else begin
      cmp(o, 16'(eo * TK));
      cmp(f, 16'(ef * TK));
    end
  endtask
  task automatic tally_and_finish();
    if (n_errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #50000;
    n_errors++;
    tally_and_finish();
  end
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    ins = 10'h100;
    repeat (4) @(posedge clk);
    cmp({13'h0, comm_l, alarm_l, fuse_l}, 16'h0);
    rstn <= 1'b1;
    repeat (6) @(posedge clk);
    #1 cmp({15'h0, comm_l}, 16'h1);
    repeat (8) @(posedge clk);
    #1 cmp({15'h0, comm_l}, 16'h0);
    foreach (rows[k]) begin
      @(posedge clk);
      ins <= rows[k].in;
      repeat (96) @(posedge clk);
      #1;
      chk(comm_l, cc, con, cof, rows[k].co, rows[k].cf);
      chk(alarm_l, ac, aon, aof, rows[k].ao, rows[k].af);
      cmp({15'h0, fuse_l}, {15'h0, rows[k].in[0]});
    end
    // Mid-run reset while alarms blink must darken every lamp
    @(posedge clk);
    rstn <= 1'b0;
    ins <= 10'h100;
    @(posedge clk);
    #1 cmp({13'h0, comm_l, alarm_l, fuse_l}, 16'h0);
    // Second release must restart the phase exactly as at power-up
    @(posedge clk);
    rstn <= 1'b1;
    repeat (6) @(posedge clk);
    #1 cmp({15'h0, comm_l}, 16'h1);
    repeat (8) @(posedge clk);
    #1 cmp({15'h0, comm_l}, 16'h0);
    cmp({15'h0, alarm_l}, 16'h0);
    tally_and_finish();
  end
endmodule
